// file: dv/sss_master_model.sv
// Model of the external master: makes shift clock frames, drives data in,
// captures data out. The bench resolves the shared line and feeds it back.
`timescale 1ns/100ps
`default_nettype none
module sss_master_model (
  // Link
  output logic      sck,
  output logic      dat,
  input  wire logic line
);
  logic drv;
  // Released line flips each half period so a stale level never matches
  initial begin
    sck = 1'b0;
    dat = 1'b0;
    drv = 1'b0;
    forever begin
      #160;
      if (!drv) dat = ~dat;
    end
  end
  // master makes clock
  // Idle low, data changes on rise, line captured well after fall
  task automatic frame(input logic [8:0] tx, input int n, input logic d, output logic [8:0] rx);
    rx = 9'h000;
    #5;
    drv = d;
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      if (d) dat = tx[i];
      #160;
      sck = 1'b0;
      #100;
      rx[i] = line;
      #60;
    end
    drv = 1'b0;
  endtask
endmodule // sss_master_model
`default_nettype wire

// file: dv/sss_slave_asserts.sv
// Checker for the slave serial port: bus handshake, read data, flags, wake.
// Sees only the top ports; bound into sss_slave at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module sss_slave_asserts (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst_b,
  // Bus
  input wire logic [sss_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [sss_pkg::BE_W-1:0]   avs_byteenable,
  input wire logic [sss_pkg::BUS_W-1:0]  avs_readdata_q,
  input wire logic                       avs_waitrequest_q,
  // Flags
  input wire logic                       wake_q,
  input wire logic                       transmit_flag_q,
  input wire logic                       receive_flag_q
);
  import sss_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Request taken on this edge
  logic taken;
  assign taken = (avs_read || avs_write) && avs_waitrequest_q;

  a_wait_answer: assert property (taken |=> !avs_waitrequest_q)
    else $error("no answer one cycle after request");
  a_wait_one: assert property (!avs_waitrequest_q |=> avs_waitrequest_q)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest_q |=> avs_waitrequest_q)
    else $error("answer without request");
  a_rdata_upper: assert property (!avs_waitrequest_q |-> avs_readdata_q[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (!(avs_read && avs_waitrequest_q) |=> $stable(avs_readdata_q))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (avs_read && taken && (avs_address >= 6'h20 || avs_address[1:0] != 2'h0)
    |=> avs_readdata_q == 32'h00000000)
    else $error("unmapped read not zero");
  a_hold_full: assert property (avs_write && taken && avs_byteenable[0] && avs_address == OFF_TX_HOLD
    |-> ##3 !transmit_flag_q)
    else $error("transmit flag set after holding write");
  a_rx_read_clear: assert property (avs_read && taken && avs_address == OFF_RX_HOLD |-> ##3 !receive_flag_q)
    else $error("receive flag kept after holding read");
  a_wake_cause: assert property (wake_q |-> transmit_flag_q || receive_flag_q
    || $past(transmit_flag_q) || $past(receive_flag_q))
    else $error("wake without a flag");
  a_wake_clear: assert property ((!transmit_flag_q && !receive_flag_q)[*2] |-> !wake_q)
    else $error("wake stays with flags clear");
endmodule // sss_slave_asserts

bind sss_slave sss_slave_asserts i_sss_slave_asserts (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_byteenable, .avs_readdata_q, .avs_waitrequest_q, .wake_q, .transmit_flag_q, .receive_flag_q);
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the slave serial port: registers, transmit, receive.
// Assumes sss_pkg and the master model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sss_pkg::*;
  logic              sys_clk, rst_b, avs_read, avs_write, sck, mdat, line;
  logic              avs_waitrequest_q, out_q, oe_b_q, wake_q, txf_q, rxf_q;
  logic [ADDR_W-1:0] avs_address;
  logic [BUS_W-1:0]  avs_writedata, avs_readdata_q, rd;
  logic [BE_W-1:0]   avs_byteenable;
  logic [8:0]        got;
  int                bad_count, checks;
  // Shared data line: device wins while its enable is low
  assign line = oe_b_q ? mdat : out_q;
  sss_slave i_sss_slave (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata_q, .avs_waitrequest_q, .shift_clock_pin(sck), .data_pin_in(line),
    .data_pin_out_q(out_q), .data_pin_oe_b_q(oe_b_q), .wake_q, .transmit_flag_q(txf_q), .receive_flag_q(rxf_q));
  sss_master_model i_sss_master_model (.sck, .dat(mdat), .line);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    chk_val({31'h0, g}, {31'h0, e}, m);
  endtask
  // One access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest_q !== 1'b0);
    rd = avs_readdata_q;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk_val(rd, e, "register read");
  endtask
  // Sync chain plus flag register latency
  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic frame(input logic [8:0] tx, input int n, input logic d);
    i_sss_master_model.frame(tx, n, d, got);
    settle;
  endtask
  task automatic t_regs;
    rdc(OFF_FLAGS, 32'h01);
    rdc(OFF_TX_HOLD, 32'h00);
    wr(OFF_DIV_HI, 8'h5a);
    rdc(OFF_DIV_HI, 32'h5a);
    wr(OFF_DIV_LO, 8'ha5);
    rdc(OFF_DIV_LO, 32'ha5);
    wr(OFF_RATE, 8'h25);
    rdc(OFF_RATE, 32'h65);
    wr(OFF_RATE, 8'h00);
    wr(6'h20, 8'hff);
    rdc(6'h20, 32'h00);
    rdc(6'h02, 32'h00);
  endtask
  task automatic t_tx;
    wr(OFF_RX_STAT, 8'h80);
    wr(OFF_TX_STAT, 8'h10);
    wr(OFF_FLAGS, 8'h04);
    wr(OFF_TX_HOLD, 8'h55);
    frame(9'h000, 8, 1'b0);
    chk_bit(oe_b_q, 1'b1, "line driven with transmitter off");
    wr(OFF_TX_STAT, 8'h30);
    frame(9'h000, 8, 1'b0);
    chk_val({23'h0, got}, 32'h55, "pending word after enable");
    wr(OFF_TX_HOLD, 8'h96);
    wr(OFF_TX_HOLD, 8'h3c);
    settle;
    chk_bit(txf_q, 1'b0, "flag while second word waits");
    chk_bit(wake_q, 1'b0, "wake while holding full");
    frame(9'h000, 8, 1'b0);
    chk_val({23'h0, got}, 32'h96, "first word");
    chk_bit(txf_q, 1'b1, "flag after reload");
    chk_bit(wake_q, 1'b1, "transmit wake");
    frame(9'h000, 8, 1'b0);
    chk_val({23'h0, got}, 32'h3c, "second word");
    wr(OFF_TX_STAT, 8'h71);
    wr(OFF_TX_HOLD, 8'h81);
    frame(9'h000, 9, 1'b0);
    chk_val({23'h0, got}, 32'h181, "nine bit word");
    wr(OFF_FLAGS, 8'h00);
    wr(OFF_TX_STAT, 8'h10);
  endtask
  task automatic t_rx;
    wr(OFF_RX_STAT, 8'ha0);
    frame(9'h0a5, 8, 1'b1);
    chk_bit(rxf_q, 1'b0, "single enable received");
    wr(OFF_TX_STAT, 8'h90);
    wr(OFF_RX_STAT, 8'h90);
    frame(9'h0a5, 8, 1'b1);
    chk_bit(rxf_q, 1'b0, "received in master select");
    wr(OFF_TX_STAT, 8'h10);
    wr(OFF_FLAGS, 8'h08);
    frame(9'h05a, 8, 1'b1);
    chk_bit(rxf_q, 1'b1, "word complete flag");
    chk_bit(wake_q, 1'b1, "receive wake");
    rdc(OFF_RX_HOLD, 32'h5a);
    settle;
    chk_bit(rxf_q, 1'b0, "flag after holding read");
    wr(OFF_RX_STAT, 8'hd0);
    frame(9'h13c, 9, 1'b1);
    rdc(OFF_RX_STAT, 32'hd1);
    rdc(OFF_RX_HOLD, 32'h3c);
    wr(OFF_RX_STAT, 8'h90);
    frame(9'h011, 8, 1'b1);
    frame(9'h022, 8, 1'b1);
    bus(1'b0, OFF_RX_STAT, 8'h00);
    chk_val(rd & 32'h06, 32'h02, "overrun reported");
    rdc(OFF_RX_HOLD, 32'h11);
    wr(OFF_RX_STAT, 8'h80);
    bus(1'b0, OFF_RX_STAT, 8'h00);
    chk_val(rd & 32'h06, 32'h00, "error cleared");
  endtask
  // Whole run needs well under this span
  initial begin
    #400000;
    bad_count++;
    final_report;
  end
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
    bad_count = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs;
    t_tx;
    t_rx;
    final_report;
  end
endmodule // testbench
`default_nettype wire

// file: src/sss_pkg.sv
// Constants for the synchronous slave serial port: register map,
// field positions, reset values and word sizes.
// Assumes a 32-bit Avalon-MM slave with byte addresses and 8-bit registers.
package sss_pkg;

  // Bus geometry
  localparam int          ADDR_W      = 6;
  localparam int          BUS_W       = 32;
  localparam int          REG_W       = 8;
  localparam int          BE_W        = 4;

  // Register byte offsets
  localparam logic [5:0]  OFF_RX_STAT = 6'h00; // receive_status_control
  localparam logic [5:0]  OFF_TX_HOLD = 6'h04; // transmit_holding
  localparam logic [5:0]  OFF_TX_STAT = 6'h08; // transmit_status_control
  localparam logic [5:0]  OFF_RATE    = 6'h0c; // rate_control
  localparam logic [5:0]  OFF_DIV_HI  = 6'h10; // rate_divider_high
  localparam logic [5:0]  OFF_DIV_LO  = 6'h14; // rate_divider_low
  localparam logic [5:0]  OFF_RX_HOLD = 6'h18; // receive_holding
  localparam logic [5:0]  OFF_FLAGS   = 6'h1c; // flags and interrupt enables

  // transmit_status_control fields
  localparam int          TX_CLOCK_SOURCE_SELECT     = 7;
  localparam int          TX_NINE     = 6;
  localparam int          TX_ON       = 5;
  localparam int          TX_SYNC     = 4;
  localparam int          TX_EMPTY    = 1;
  localparam int          TX_NINTH    = 0;

  // receive_status_control fields
  localparam int          RX_SERIAL_PORT_ENABLE     = 7;
  localparam int          RX_NINE     = 6;
  localparam int          RX_SINGLE_RECEIVE_ENABLE     = 5;
  localparam int          RX_CONTINUOUS_RECEIVE_ENABLE     = 4;
  localparam int          RX_FERR     = 2;
  localparam int          RX_OERR     = 1;
  localparam int          RX_NINTH    = 0;

  // rate_control fields
  localparam int          RATE_IDLE   = 6;
  localparam int          RATE_SCKP   = 4;

  // Flags register fields
  localparam int          FL_TXF      = 0;
  localparam int          FL_RXF      = 1;
  localparam int          FL_TXIE     = 2;
  localparam int          FL_RXIE     = 3;

  // Writable masks and reset values
  localparam logic [7:0]  TX_WR_MASK  = 8'hfd;
  localparam logic [7:0]  RX_WR_MASK  = 8'hf8;
  localparam logic [7:0]  RATE_WR_MASK = 8'hbf;
  localparam logic [7:0]  FL_WR_MASK  = 8'h0c;
  localparam logic [7:0]  REG_RESET   = 8'h00;

  // Word sizes in shift clock periods
  localparam int          WORD_MAX    = 9;
  localparam int          CNT_W       = 4;
  localparam logic [3:0]  LAST_8      = 4'h7;
  localparam logic [3:0]  LAST_9      = 4'h8;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;

  // Pin synchroniser lanes
  localparam int          PIN_W       = 2;
  localparam int          PIN_CK      = 0;
  localparam int          PIN_DT      = 1;

  typedef enum logic [0:0] {
    SSS_TX_IDLE  = 1'b0,
    SSS_TX_SHIFT = 1'b1
  } sss_tx_state_t;

endpackage

// file: src/sss_slave.sv
// Synchronous slave serial port: registers on Avalon-MM, shift clock and
// data arrive from an external master on pins.
// Assumes the master drives the shift clock; data pin is shared, the
// testbench resolves it from the active-low output enable.
//
// How it works
// - Slave mode while clock source bit clear
// - Shift clock comes only from pin
// - Shifting needs sys_clk to sample the pin edges
// - Transmit matches master transmit behaviour
// - First word loads shifter at once
// - Second word waits, transmit flag clear
// - After shift-out reload, then set flag
// - Transmit flag with enable raises wake
// - Transmitter on, then write starts word
// - Single receive enable ignored in slave
// - Continuous receive completes words anytime
// - Completed word moves to receive holding
// - Receive flag with enable raises wake
// - Receive flag set on completed word
// - Status gives ninth bit, errors; holding data
// - Clearing continuous receive clears errors
// - Receive data sampled on falling clock
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module sss_slave (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Avalon-MM slave
  input  wire logic [sss_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [sss_pkg::BUS_W-1:0] avs_writedata,
  input  wire logic [sss_pkg::BE_W-1:0]  avs_byteenable,
  output logic      [sss_pkg::BUS_W-1:0] avs_readdata_q,
  output logic                           avs_waitrequest_q,
  // Link pins
  input  wire logic                      shift_clock_pin,
  input  wire logic                      data_pin_in,
  output logic                           data_pin_out_q,
  output logic                           data_pin_oe_b_q,
  // Wake request and flags
  output logic                           wake_q,
  output logic                           transmit_flag_q,
  output logic                           receive_flag_q
);
  import sss_pkg::*;

  // Register state
  logic [REG_W-1:0]    tx_stat_q;
  logic [REG_W-1:0]    rx_stat_q;
  logic [REG_W-1:0]    rate_q;
  logic [REG_W-1:0]    div_hi_q;
  logic [REG_W-1:0]    div_lo_q;
  logic [REG_W-1:0]    tx_hold_q;
  logic                tx_hold_full_q;
  logic [REG_W-1:0]    rx_hold_q;
  logic                rx_full_q;
  logic                rx_ninth_q;
  logic                overrun_q;
  logic                txie_q;
  logic                rxie_q;

  // Shift state
  sss_tx_state_t       tx_state_q;
  logic [WORD_MAX-1:0] tx_sh_q;
  logic [CNT_W-1:0]    tx_cnt_q;
  logic                tx_nine_q;
  logic [WORD_MAX-1:0] rx_sh_q;
  logic [CNT_W-1:0]    rx_cnt_q;
  logic [WORD_MAX-1:0] rx_word_d;

  // Pin edges
  logic [PIN_W-1:0]    pin_lvl;
  logic                ck_prev_q;
  logic                ck_now;
  logic                ck_rise;
  logic                ck_fall;

  // Bus decode
  logic                take;
  logic                ack;
  logic                wr_ok;
  logic                rd_take;
  logic [REG_W-1:0]    wbyte;
  logic [REG_W-1:0]    rdata_d;

  // Mode and sequencing
  logic                slave_on;
  logic                tx_active;
  logic                rx_active;
  logic                tx_load;
  logic                tx_done;
  logic                rx_done;
  logic [CNT_W-1:0]    tx_last;
  logic [CNT_W-1:0]    rx_last;
  logic                rx_pop;

  sss_sync #(
    .W (PIN_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin_in  ({data_pin_in, shift_clock_pin}),
    .level_q (pin_lvl)
  );

  // Edges found on the external clock; polarity bit flips the sense
  assign ck_now  = pin_lvl[PIN_CK] ^ rate_q[RATE_SCKP];
  assign ck_rise = ck_now & ~ck_prev_q;
  assign ck_fall = ~ck_now & ck_prev_q;

  // Previous clock level for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_now;
    end
  end

  assign slave_on  = rx_stat_q[RX_SERIAL_PORT_ENABLE] & tx_stat_q[TX_SYNC] & ~tx_stat_q[TX_CLOCK_SOURCE_SELECT];
  // Of the two receive enables, only continuous enable gates the receiver
  assign rx_active = slave_on & rx_stat_q[RX_CONTINUOUS_RECEIVE_ENABLE];
  // Receive owns the shared data pin, so transmit yields to it
  assign tx_active = slave_on & tx_stat_q[TX_ON] & ~rx_stat_q[RX_CONTINUOUS_RECEIVE_ENABLE];

  // One wait cycle per access; request seen while waitrequest is high
  // Completes in the low cycle, so writes and pops land only on that edge
  assign take    = (avs_read | avs_write) & avs_waitrequest_q;
  assign ack     = (avs_read | avs_write) & ~avs_waitrequest_q;
  assign wr_ok   = ack & avs_write & avs_byteenable[0];
  assign rd_take = take & avs_read;
  assign wbyte   = avs_writedata[REG_W-1:0];
  assign rx_pop  = ack & avs_read & (avs_address == OFF_RX_HOLD);

  // Waitrequest drops for exactly the answering cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      avs_waitrequest_q <= 1'b1;
    end else begin
      avs_waitrequest_q <= ~take;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = REG_RESET;
    unique case (avs_address)
      OFF_RX_STAT: begin
        rdata_d           = rx_stat_q;
        rdata_d[RX_FERR]  = 1'b0; // No framing errors in synchronous mode
        rdata_d[RX_OERR]  = overrun_q;
        rdata_d[RX_NINTH] = rx_ninth_q;
      end
      OFF_TX_STAT: begin
        rdata_d           = tx_stat_q;
        rdata_d[TX_EMPTY] = (tx_state_q == SSS_TX_IDLE);
      end
      OFF_RATE: begin
        rdata_d            = rate_q;
        rdata_d[RATE_IDLE] = (rx_cnt_q == CNT_ZERO);
      end
      OFF_DIV_HI:  rdata_d = div_hi_q;
      OFF_DIV_LO:  rdata_d = div_lo_q;
      OFF_RX_HOLD: rdata_d = rx_hold_q;
      OFF_FLAGS: begin
        rdata_d[FL_TXF]  = ~tx_hold_full_q;
        rdata_d[FL_RXF]  = rx_full_q;
        rdata_d[FL_TXIE] = txie_q;
        rdata_d[FL_RXIE] = rxie_q;
      end
      default: rdata_d = REG_RESET;
    endcase
  end

  // Read data captured with the request; upper lanes stay zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      avs_readdata_q <= '0;
    end else if (rd_take) begin
      avs_readdata_q <= {{(BUS_W-REG_W){1'b0}}, rdata_d};
    end
  end

  // Control registers written from the bus
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_stat_q <= REG_RESET;
      rx_stat_q <= REG_RESET;
      rate_q    <= REG_RESET;
      div_hi_q  <= REG_RESET;
      div_lo_q  <= REG_RESET;
      txie_q    <= 1'b0;
      rxie_q    <= 1'b0;
    end else if (wr_ok) begin
      unique case (avs_address)
        OFF_TX_STAT: tx_stat_q <= wbyte & TX_WR_MASK;
        OFF_RX_STAT: rx_stat_q <= wbyte & RX_WR_MASK;
        OFF_RATE:    rate_q    <= wbyte & RATE_WR_MASK;
        OFF_DIV_HI:  div_hi_q  <= wbyte; // Stored only; no rate generator here
        OFF_DIV_LO:  div_lo_q  <= wbyte;
        OFF_FLAGS: begin
          txie_q <= wbyte[FL_TXIE];
          rxie_q <= wbyte[FL_RXIE];
        end
        default: ;
      endcase
    end
  end

  // Word lengths follow the nine-bit selects
  assign tx_last = tx_nine_q ? LAST_9 : LAST_8;
  assign rx_last = rx_stat_q[RX_NINE] ? LAST_9 : LAST_8;

  // Idle shifter takes a waiting word at once
  // Finished word pulls the next one in
  assign tx_done = tx_active & (tx_state_q == SSS_TX_SHIFT) & ck_fall & (tx_cnt_q == tx_last);
  assign tx_load = tx_active & tx_hold_full_q & ((tx_state_q == SSS_TX_IDLE) | tx_done);

  // Holding register fills on write; load empties it
  // Word waits while shifter busy, flag stays clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_hold_q      <= REG_RESET;
      tx_hold_full_q <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_hold_full_q <= 1'b0;
      end
      // A write in the load cycle still counts as a new word
      if (wr_ok && avs_address == OFF_TX_HOLD) begin
        tx_hold_q      <= wbyte;
        tx_hold_full_q <= 1'b1;
      end
    end
  end

  // Transmit shifter, one bit per external clock period
  // Steps on pin edges sampled by sys_clk, so it stops if sys_clk stops
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_state_q <= SSS_TX_IDLE;
      tx_sh_q    <= '0;
      tx_cnt_q   <= CNT_ZERO;
      tx_nine_q  <= 1'b0;
    end else if (!tx_active) begin
      tx_state_q <= SSS_TX_IDLE;
      tx_cnt_q   <= CNT_ZERO;
    end else if (tx_load) begin
      // Ninth bit latched with the data
      tx_sh_q    <= {tx_stat_q[TX_NINTH], tx_hold_q};
      tx_nine_q  <= tx_stat_q[TX_NINE];
      tx_cnt_q   <= CNT_ZERO;
      tx_state_q <= SSS_TX_SHIFT;
    end else begin
      unique case (tx_state_q)
        SSS_TX_IDLE: tx_cnt_q <= CNT_ZERO;
        SSS_TX_SHIFT: begin
          if (tx_done) begin
            tx_state_q <= SSS_TX_IDLE;
            tx_cnt_q   <= CNT_ZERO;
          end else if (ck_fall) begin
            tx_cnt_q <= tx_cnt_q + CNT_ONE;
          end
        end
      endcase
    end
  end

  // Data changes on rising clock so the master samples it on falling
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_pin_out_q <= 1'b1;
    end else if (!tx_active || tx_state_q == SSS_TX_IDLE) begin
      data_pin_out_q <= 1'b1;
    end else if (ck_rise) begin
      data_pin_out_q <= tx_sh_q[tx_cnt_q];
    end
  end

  // Drive the data pin whenever the transmitter is active, idle or shifting
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_pin_oe_b_q <= 1'b1;
    end else begin
      data_pin_oe_b_q <= ~tx_active;
    end
  end

  // Completing word includes the bit sampled this cycle
  always_comb begin
    rx_word_d           = rx_sh_q;
    rx_word_d[rx_cnt_q] = pin_lvl[PIN_DT];
  end

  // Receiver steps only on sys_clk samples of the pin clock
  assign rx_done = rx_active & ck_fall & (rx_cnt_q == rx_last);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_sh_q  <= '0;
      rx_cnt_q <= CNT_ZERO;
    end else if (!rx_active) begin
      rx_cnt_q <= CNT_ZERO;
    end else if (ck_fall) begin
      rx_sh_q  <= rx_word_d;
      rx_cnt_q <= rx_done ? CNT_ZERO : rx_cnt_q + CNT_ONE;
    end
  end

  // Word moves to holding unless holding still full
  // Receive flag set on completion; set beats a same-cycle read
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_hold_q  <= REG_RESET;
      rx_ninth_q <= 1'b0;
      rx_full_q  <= 1'b0;
    end else begin
      if (rx_pop) begin
        rx_full_q <= 1'b0;
      end
      if (rx_done && (!rx_full_q || rx_pop)) begin
        rx_hold_q  <= rx_word_d[REG_W-1:0];
        rx_ninth_q <= rx_stat_q[RX_NINE] & rx_word_d[REG_W];
        rx_full_q  <= 1'b1;
      end
    end
  end

  // Overrun held until continuous receive is cleared
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      overrun_q <= 1'b0;
    end else if (rx_done && rx_full_q && !rx_pop) begin
      overrun_q <= 1'b1;
    end else if (!rx_stat_q[RX_CONTINUOUS_RECEIVE_ENABLE]) begin
      overrun_q <= 1'b0;
    end
  end

  // Transmit wake when holding empty and enabled
  // Receive wake when word waiting and enabled
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wake_q          <= 1'b0;
      transmit_flag_q <= 1'b0;
      receive_flag_q  <= 1'b0;
    end else begin
      wake_q          <= (~tx_hold_full_q & txie_q) | (rx_full_q & rxie_q);
      transmit_flag_q <= ~tx_hold_full_q;
      receive_flag_q  <= rx_full_q;
    end
  end

endmodule // sss_slave
`default_nettype wire

// file: src/sss_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to sys_clk; output moves once stages two
// and three agree.
`timescale 1ns/100ps
`default_nettype none
module sss_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // Stage one is seen only by stage two
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Accept a change only when two late stages agree
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          level_q[i] <= 1'b0;
        end else if (s2_q == s3_q) begin
          level_q[i] <= s3_q;
        end
      end
    end
  endgenerate

endmodule // sss_sync
`default_nettype wire
